/* File: design/fpec_array.sv */
// Nonvolatile byte array model with one read port and one write port.
`timescale 1ns/1ps
`include "fpec_defines.svh"

module fpec_array #(
    parameter int ADDR_W = 14
) (
    // Clock
    input  wire logic              clk,
    // Read port
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [7:0]        rd_data,
    // Write port
    input  wire logic              wr_en,
    input  wire logic              wr_prog,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]        wr_data
);

    logic [7:0] mem [0:(1<<ADDR_W)-1];

    // The cells are not reset; they start from the factory erased state.
    initial
    begin
        for (int i = 0; i < (1 << ADDR_W); i++)
        begin
            mem[i] = `FPEC_ERASED;
        end
    end

    assign rd_data = mem[rd_addr];

    // Programming can only clear bits, so it is an AND with the old cell.
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            if (wr_prog)
                mem[wr_addr] <= mem[wr_addr] & wr_data;
            else
                mem[wr_addr] <= wr_data;
        end
    end

endmodule : fpec_array

/* File: design/fpec_defines.svh */
// Addresses, field positions, reset values and timing counts of the program/erase control.
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH

`define FPEC_CTRL_ADDR      16'hfe08
`define FPEC_BPR_ADDR       16'hff7e
`define FPEC_USER_LO        16'hc000
`define FPEC_USER_HI        16'hfdff
`define FPEC_VEC_LO         16'hffd4
`define FPEC_PROT_BASE      16'hc000
`define FPEC_USER_BYTES     15872
`define FPEC_VEC_BYTES      44
`define FPEC_ARRAY_BYTES    16384
`define FPEC_PAGE_BYTES     64
`define FPEC_ROW_BYTES      32
`define FPEC_PAGE_LSB       6
`define FPEC_ROW_LSB        5
`define FPEC_BIT_HIGH_VOLTAGE_ENABLE       3
`define FPEC_BIT_MASS       2
`define FPEC_BIT_ERASE      1
`define FPEC_BIT_PGM        0
`define FPEC_CTRL_RST       4'h0
`define FPEC_CTRL_PAD       4'h0
`define FPEC_ERASED         8'hff
`define FPEC_BPR_OPEN       8'hff
`define FPEC_BPR_RST        8'h00
`define FPEC_VIEW_BLANK     8'h00
`define FPEC_CLK_KHZ        40000
`define FPEC_T_NVS_NS       10000
`define FPEC_NVS_CYC        ((`FPEC_T_NVS_NS * `FPEC_CLK_KHZ + 999999) / 1000000)

`endif

/* File: design/fpec_pkg.sv */
// Types shared by the program/erase control modules.
package fpec_pkg;

    typedef struct packed {
        logic high_voltage_enable;
        logic mass;
        logic erase;
        logic program_select;
    } fpec_ctrl_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fpec_req_s;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_SELECTED,
        SEQ_BPR_READ,
        SEQ_NVS_WAIT,
        SEQ_ARMED,
        SEQ_HV
    } fpec_seq_e;

endpackage : fpec_pkg

/* File: design/fpec_protect.sv */
// Decode of the protection boundary byte into a protected range.
`timescale 1ns/1ps
`include "fpec_defines.svh"

module fpec_protect (
    // Boundary value and address under test
    input  wire logic [7:0]  bpr,
    input  wire logic [15:0] addr,
    // Result
    output logic             prot_hit,
    output logic             mass_ok
);

    logic [15:0] start;

    // Each step of the boundary moves the start by one page; all ones opens everything.
    assign start    = `FPEC_PROT_BASE + {2'b00, bpr, 6'h00};
    assign prot_hit = (bpr != `FPEC_BPR_OPEN) && (addr >= start);
    assign mass_ok  = (bpr == `FPEC_BPR_OPEN);

endmodule : fpec_protect

/* File: design/fpec_top.sv */
// Program/erase control of the embedded nonvolatile array, reached by CPU reads and writes.
`timescale 1ns/1ps
`include "fpec_defines.svh"

module fpec_top #(
    parameter int ADDR_W  = 14,
    parameter int NVS_CYC = `FPEC_NVS_CYC
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // CPU access
    input  fpec_pkg::fpec_req_s    cpu_req,
    output logic      [7:0]        cpu_rdata,
    // Security
    input  wire logic              view_lock,
    // Analogue controls and status
    output logic                   pump_on,
    output logic                   hv_to_array,
    output logic                   erase_busy
);

    localparam int CNT_W = $clog2(`FPEC_ARRAY_BYTES) + 1;
    localparam int NVS_W = $clog2(NVS_CYC + 1) + 1;

    logic rst_meta_q;
    logic rst_sync_n;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // Address decode.
    logic              in_user;
    logic              in_vec;
    logic              in_array;
    logic              ctrl_hit;
    logic              bpr_hit;
    logic [ADDR_W-1:0] cpu_idx;

    assign in_user  = (cpu_req.addr >= `FPEC_USER_LO) && (cpu_req.addr <= `FPEC_USER_HI);
    assign in_vec   = (cpu_req.addr >= `FPEC_VEC_LO);
    assign bpr_hit  = (cpu_req.addr == `FPEC_BPR_ADDR);
    assign in_array = in_user || in_vec || bpr_hit;
    assign ctrl_hit = (cpu_req.addr == `FPEC_CTRL_ADDR);
    assign cpu_idx  = cpu_req.addr[ADDR_W-1:0];

    // State.
    fpec_pkg::fpec_ctrl_s ctrl_q;
    fpec_pkg::fpec_ctrl_s ctrl_d;
    fpec_pkg::fpec_seq_e  seq_q;
    fpec_pkg::fpec_seq_e  seq_d;
    logic [15:0]          lat_q;
    logic [15:0]          lat_d;
    logic [7:0]           bpr_q;
    logic [7:0]           bpr_d;
    logic [NVS_W-1:0]     nvs_q;
    logic [NVS_W-1:0]     nvs_d;
    logic [ADDR_W-1:0]    ers_addr_q;
    logic [ADDR_W-1:0]    ers_addr_d;
    logic [CNT_W-1:0]     ers_left_q;
    logic [CNT_W-1:0]     ers_left_d;
    logic [7:0]           rdata_q;
    logic [7:0]           rdata_d;

    // Array and protection.
    logic [7:0]        arr_rdata;
    logic              arr_we;
    logic              arr_prog;
    logic [ADDR_W-1:0] arr_waddr;
    logic [7:0]        arr_wdata;
    logic              prot_hit;
    logic              mass_ok;

    fpec_array #(
        .ADDR_W (ADDR_W)
    ) u_array (
        .clk     (ref_clk),
        .rd_addr (cpu_idx),
        .rd_data (arr_rdata),
        .wr_en   (arr_we),
        .wr_prog (arr_prog),
        .wr_addr (arr_waddr),
        .wr_data (arr_wdata)
    );

    // The boundary is judged on the address latched by the preparatory write.
    fpec_protect u_protect (
        .bpr      (bpr_q),
        .addr     (lat_q),
        .prot_hit (prot_hit),
        .mass_ok  (mass_ok)
    );

    // Control register write after the select interlock.
    fpec_pkg::fpec_ctrl_s wr_val;
    logic                 ctrl_wr;
    logic                 sel_d;
    logic                 hv_ok;

    always_comb
    begin
        ctrl_wr = cpu_req.wr && ctrl_hit;
        wr_val  = cpu_req.wdata[3:0];
        // A write that would leave both selects high keeps both as they were.
        if (wr_val.program_select && wr_val.erase)
        begin
            wr_val.program_select   = ctrl_q.program_select;
            wr_val.erase = ctrl_q.erase;
        end
        sel_d = wr_val.program_select || wr_val.erase;
        hv_ok = sel_d && (seq_q == fpec_pkg::SEQ_ARMED) && !prot_hit
                && !(wr_val.erase && wr_val.mass && !mass_ok);
        if (!ctrl_q.high_voltage_enable && !hv_ok)
            wr_val.high_voltage_enable = 1'b0;
    end

    // Next state of the sequence, control bits and erase walker.
    always_comb
    begin
        ctrl_d     = ctrl_q;
        seq_d      = seq_q;
        lat_d      = lat_q;
        bpr_d      = bpr_q;
        nvs_d      = nvs_q;
        ers_addr_d = ers_addr_q;
        ers_left_d = ers_left_q;
        rdata_d    = rdata_q;

        if (ctrl_wr)
            ctrl_d = wr_val;

        if (cpu_req.rd)
        begin
            if (ctrl_hit)
                rdata_d = {`FPEC_CTRL_PAD, ctrl_q};
            else if (in_array && view_lock)
                rdata_d = `FPEC_VIEW_BLANK;
            else if (in_array)
                rdata_d = arr_rdata;
            else
                rdata_d = 8'h00;
            if (bpr_hit)
                bpr_d = arr_rdata;
        end

        case (seq_q)
            fpec_pkg::SEQ_IDLE:
            begin
                if (ctrl_q.program_select || ctrl_q.erase)
                    seq_d = fpec_pkg::SEQ_SELECTED;
            end
            fpec_pkg::SEQ_SELECTED:
            begin
                if (cpu_req.rd && bpr_hit)
                    seq_d = fpec_pkg::SEQ_BPR_READ;
            end
            fpec_pkg::SEQ_BPR_READ:
            begin
                // The preparatory write only latches the address; no cell changes.
                if (cpu_req.wr && in_array)
                begin
                    lat_d = cpu_req.addr;
                    nvs_d = NVS_W'(NVS_CYC - 1);
                    seq_d = fpec_pkg::SEQ_NVS_WAIT;
                end
            end
            fpec_pkg::SEQ_NVS_WAIT:
            begin
                if (nvs_q == '0)
                    seq_d = fpec_pkg::SEQ_ARMED;
                else
                    nvs_d = nvs_q - 1'b1;
            end
            fpec_pkg::SEQ_ARMED:
            begin
                if (ctrl_wr && wr_val.high_voltage_enable)
                begin
                    seq_d = fpec_pkg::SEQ_HV;
                    if (wr_val.erase && wr_val.mass)
                    begin
                        ers_addr_d = '0;
                        ers_left_d = CNT_W'(`FPEC_ARRAY_BYTES);
                    end
                    else if (wr_val.erase)
                    begin
                        ers_addr_d = {lat_q[ADDR_W-1:`FPEC_PAGE_LSB], 6'h00};
                        ers_left_d = CNT_W'(`FPEC_PAGE_BYTES);
                    end
                    else
                        ers_left_d = '0;
                end
            end
            fpec_pkg::SEQ_HV:
            begin
                if (ers_left_q != '0 && ctrl_q.erase)
                begin
                    ers_addr_d = ers_addr_q + 1'b1;
                    ers_left_d = ers_left_q - 1'b1;
                end
                if (!ctrl_d.high_voltage_enable)
                begin
                    seq_d      = fpec_pkg::SEQ_IDLE;
                    ers_left_d = '0;
                end
            end
            default:
            begin
                seq_d = fpec_pkg::SEQ_IDLE;
            end
        endcase

        // Dropping both selects outside high voltage abandons the preparation.
        if (seq_q != fpec_pkg::SEQ_HV && !ctrl_d.program_select && !ctrl_d.erase)
            seq_d = fpec_pkg::SEQ_IDLE;
    end

    // Array writes: erase walker first, then row programming by the CPU.
    always_comb
    begin
        arr_we    = 1'b0;
        arr_prog  = 1'b0;
        arr_waddr = cpu_idx;
        arr_wdata = cpu_req.wdata;
        if (seq_q == fpec_pkg::SEQ_HV && ctrl_q.high_voltage_enable)
        begin
            if (ctrl_q.erase && ers_left_q != '0)
            begin
                arr_we    = 1'b1;
                arr_waddr = ers_addr_q;
                arr_wdata = `FPEC_ERASED;
            end
            else if (ctrl_q.program_select && cpu_req.wr && in_array
                     && cpu_req.addr[15:`FPEC_ROW_LSB] == lat_q[15:`FPEC_ROW_LSB])
            begin
                arr_we   = 1'b1;
                arr_prog = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ctrl_q     <= `FPEC_CTRL_RST;
            seq_q      <= fpec_pkg::SEQ_IDLE;
            lat_q      <= 16'h0000;
            bpr_q      <= `FPEC_BPR_RST;
            nvs_q      <= '0;
            ers_addr_q <= '0;
            ers_left_q <= '0;
            rdata_q    <= 8'h00;
        end
        else
        begin
            ctrl_q     <= ctrl_d;
            seq_q      <= seq_d;
            lat_q      <= lat_d;
            bpr_q      <= bpr_d;
            nvs_q      <= nvs_d;
            ers_addr_q <= ers_addr_d;
            ers_left_q <= ers_left_d;
            rdata_q    <= rdata_d;
        end
    end

    assign cpu_rdata   = rdata_q;
    assign pump_on     = ctrl_q.high_voltage_enable;
    assign hv_to_array = ctrl_q.high_voltage_enable;
    assign erase_busy  = (ers_left_q != '0);

endmodule : fpec_top

/* File: sim/fpec_cpu_model.sv */
// Behavioural CPU core issuing register and array accesses.
`timescale 1ns/1ps

module fpec_cpu_model #(
    parameter int NVS_CYC = 4
) (
    // Clock
    input wire logic            ref_clk,
    // Bus
    output fpec_pkg::fpec_req_s cpu_req,
    input wire logic [7:0]      cpu_rdata
);
    initial cpu_req = '0;

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #2;
        cpu_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        #2;
        cpu_req.wr = 1'b0;
        cpu_req.wdata = ~d;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #2;
        cpu_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        #2;
        cpu_req.rd = 1'b0;
        d = cpu_rdata;
    endtask : rd

    // Select, boundary read, latch, settle, then raise high voltage.
    task automatic start_hv(input logic [7:0] ctl, input logic [15:0] a);
        logic [7:0] b;
        wr(16'hfe08, ctl);
        rd(16'hff7e, b);
        wr(a, 8'h00);
        repeat (NVS_CYC + 1) @(posedge ref_clk);
        wr(16'hfe08, ctl | 8'h08);
    endtask : start_hv
endmodule : fpec_cpu_model

/* File: sim/fpec_top_properties.sv */
// Port-level timing checks of the program/erase control.
`timescale 1ns/1ps

module fpec_top_properties (
    // Clock and reset
    input wire logic           ref_clk,
    input wire logic           rst_n,
    // CPU access
    input fpec_pkg::fpec_req_s cpu_req,
    input wire logic [7:0]     cpu_rdata,
    input wire logic           view_lock,
    // Analogue controls and status
    input wire logic           pump_on,
    input wire logic           hv_to_array,
    input wire logic           erase_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic ctl_wr;
    logic ctl_rd;
    assign ctl_wr = cpu_req.wr && cpu_req.addr == 16'hfe08;
    assign ctl_rd = cpu_req.rd && cpu_req.addr == 16'hfe08;

    pump_tracks_hv_a: assert property (pump_on == hv_to_array)
        else $error("pump and array voltage differ");
    hv_cause_a: assert property ($rose(pump_on)
        |-> $past(ctl_wr) && $past(cpu_req.wdata[3]))
        else $error("pump rose without a control write");
    hv_select_a: assert property ($rose(pump_on)
        |-> $past(cpu_req.wdata[1]) != $past(cpu_req.wdata[0]))
        else $error("pump rose without exactly one select");
    hv_clear_a: assert property (ctl_wr && !cpu_req.wdata[3] |=> !pump_on && !hv_to_array)
        else $error("pump stayed on after clear");
    hv_refused_a: assert property (ctl_wr && !pump_on
        && cpu_req.wdata[1:0] == 2'b00 |=> !pump_on)
        else $error("pump rose with no select");
    ctrl_pad_a: assert property (ctl_rd |=> cpu_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    ctrl_excl_a: assert property (ctl_rd |=> cpu_rdata[1:0] != 2'b11)
        else $error("both selects read as one");
    lock_read_a: assert property (cpu_req.rd && view_lock && cpu_req.addr >= 16'hc000
        && cpu_req.addr <= 16'hfdff |=> cpu_rdata == 8'h00)
        else $error("locked array read not blank");
    busy_with_hv_a: assert property ($rose(erase_busy)
        |-> pump_on && $past(cpu_req.wdata[1]))
        else $error("erase walker started without erase voltage");
endmodule : fpec_top_properties

/* File: sim/test_flash_program_erase_control.sv */
// Self-checking bench for the program/erase control.
`timescale 1ns/1ps

module test_flash_program_erase_control;
    localparam int NVS = 4;
    logic                ref_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                view_lock = 1'b0;
    fpec_pkg::fpec_req_s cpu_req;
    logic [7:0]          cpu_rdata;
    logic                pump_on;
    logic                hv_to_array;
    logic                erase_busy;
    int                  n_fail = 0;
    int                  checks_done = 0;

    always #12.5 ref_clk = ~ref_clk;

    fpec_top #(.NVS_CYC(NVS)) dut (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .cpu_req     (cpu_req),
        .cpu_rdata   (cpu_rdata),
        .view_lock   (view_lock),
        .pump_on     (pump_on),
        .hv_to_array (hv_to_array),
        .erase_busy  (erase_busy)
    );

    fpec_cpu_model #(.NVS_CYC(NVS)) cpu (
        .ref_clk   (ref_clk),
        .cpu_req   (cpu_req),
        .cpu_rdata (cpu_rdata)
    );

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic expect_rd(input string what, input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        cpu.rd(a, d);
        check(what, {8'h00, e}, {8'h00, d});
    endtask : expect_rd

    task automatic stop_hv;
        cpu.wr(16'hfe08, 8'h08);
        cpu.wr(16'hfe08, 8'h00);
        check("pump off", 16'h0000, {15'h0000, pump_on});
    endtask : stop_hv

    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        cpu.start_hv(8'h01, a);
        check("pump on", 16'h0001, {15'h0000, pump_on});
        check("array voltage", 16'h0001, {15'h0000, hv_to_array});
        cpu.wr(a, d);
        stop_hv();
    endtask : prog

    task automatic erase(input logic [7:0] ctl, input logic [15:0] a, input int n);
        int cnt = 0;
        cpu.start_hv(ctl, a);
        while (erase_busy === 1'b1 && cnt < 20000)
        begin
            @(posedge ref_clk);
            #2;
            cnt++;
        end
        check("erase length", n[15:0], cnt[15:0]);
        stop_hv();
    endtask : erase

    task automatic t_reset_and_interlock;
        expect_rd("control at reset", 16'hfe08, 8'h00);
        expect_rd("unmapped", 16'h0040, 8'h00);
        expect_rd("erased cell", 16'hc000, 8'hff);
        cpu.wr(16'hfe08, 8'h03);
        expect_rd("both selects", 16'hfe08, 8'h00);
        cpu.wr(16'hfe08, 8'h01);
        cpu.wr(16'hfe08, 8'h03);
        expect_rd("selects kept", 16'hfe08, 8'h01);
        cpu.wr(16'hfe08, 8'h09);
        expect_rd("hv without preparation", 16'hfe08, 8'h01);
        cpu.wr(16'hfe08, 8'h08);
        expect_rd("hv without select", 16'hfe08, 8'h00);
        check("pump refused", 16'h0000, {15'h0000, pump_on});
        $display("test reset_and_interlock done");
    endtask : t_reset_and_interlock

    task automatic t_program_and_lock;
        prog(16'hc021, 8'h5a);
        expect_rd("programmed", 16'hc021, 8'h5a);
        expect_rd("row neighbour", 16'hc020, 8'hff);
        prog(16'hc021, 8'h0f);
        expect_rd("bits only cleared", 16'hc021, 8'h0a);
        prog(16'hc040, 8'hf0);
        cpu.start_hv(8'h01, 16'hc040);
        cpu.wr(16'hc060, 8'h00);
        stop_hv();
        expect_rd("other row kept", 16'hc060, 8'hff);
        view_lock = 1'b1;
        expect_rd("locked read", 16'hc040, 8'h00);
        view_lock = 1'b0;
        expect_rd("unlocked read", 16'hc040, 8'hf0);
        $display("test program_and_lock done");
    endtask : t_program_and_lock

    task automatic t_erase;
        erase(8'h02, 16'hc000, 64);
        expect_rd("page erased", 16'hc021, 8'hff);
        expect_rd("next page kept", 16'hc040, 8'hf0);
        erase(8'h06, 16'hc000, 16384);
        expect_rd("mass erased", 16'hc040, 8'hff);
        expect_rd("vector erased", 16'hffd4, 8'hff);
        $display("test erase done");
    endtask : t_erase

    // Reset lands while high voltage is on; cells must survive, control must not.
    task automatic t_mid_reset;
        cpu.start_hv(8'h01, 16'hc080);
        cpu.wr(16'hc080, 8'h55);
        rst_n = 1'b0;
        @(posedge ref_clk);
        #2;
        check("pump in reset", 16'h0000, {15'h0000, pump_on});
        repeat (5) @(posedge ref_clk);
        #2;
        rst_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        expect_rd("control after reset", 16'hfe08, 8'h00);
        expect_rd("kept over reset", 16'hc080, 8'h55);
        $display("test mid_reset done");
    endtask : t_mid_reset

    task automatic t_protect;
        prog(16'hff7e, 8'h00);
        expect_rd("boundary byte", 16'hff7e, 8'h00);
        cpu.start_hv(8'h01, 16'hc100);
        check("protected program", 16'h0000, {15'h0000, pump_on});
        cpu.wr(16'hfe08, 8'h00);
        cpu.start_hv(8'h06, 16'hc000);
        check("mass refused", 16'h0000, {15'h0000, pump_on});
        expect_rd("hv bit clear", 16'hfe08, 8'h06);
        cpu.wr(16'hfe08, 8'h00);
        $display("test protect done");
    endtask : t_protect

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (6) @(posedge ref_clk);
        #2;
        rst_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset_and_interlock();
        t_program_and_lock();
        t_erase();
        t_mid_reset();
        t_protect();
        finish_test();
    end

    // About 17,000 cycles are expected; the limit leaves wide margin.
    initial
    begin
        #1500000;
        n_fail++;
        finish_test();
    end
endmodule : test_flash_program_erase_control

bind fpec_top fpec_top_properties chk (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .cpu_req     (cpu_req),
    .cpu_rdata   (cpu_rdata),
    .view_lock   (view_lock),
    .pump_on     (pump_on),
    .hv_to_array (hv_to_array),
    .erase_busy  (erase_busy)
);
